// [logic/lid_regs.svh]
// Purpose: Constants for the link indicator driver: register offset, field positions,
//          reset value and blink timing.
// Assumes: 200 MHz core clock.
// Notes:   Included by bare name; definitions only.
`ifndef LID_REGS_SVH
`define LID_REGS_SVH

// Register index of the indicator configuration register.
`define LID_CFG_ADDR 5'h1E
`define LID_ADDR_W 5
`define LID_DATA_W 16
`define LID_CFG_RESET 16'h18F4

// Field positions inside the configuration register.
`define LID_RATE_BIT 15
`define LID_FLASH2_BIT 14
`define LID_POL2_BIT 13
`define LID_SEL2_HI 12
`define LID_SEL2_LO 10
`define LID_FLASH1_BIT 9
`define LID_POL1_BIT 8
`define LID_SEL1_HI 7
`define LID_SEL1_LO 5
`define LID_FLASH0_BIT 4
`define LID_POL0_BIT 3
`define LID_SEL0_HI 2
`define LID_SEL0_LO 0

// Blink timing: half periods in ms and clock rate in kHz.
`define LID_SLOW_HALF_MS 200
`define LID_FAST_HALF_MS 83
`define LID_CLK_KHZ 200000
`define LID_CNT_W 26

`endif

// [logic/lid_pkg.sv]
// Purpose: Shared types of the link indicator driver.
// Assumes: Constants come from lid_regs.svh.
// Notes:   Source codes follow the encoding of the source select fields.
package lid_pkg;

  typedef enum logic [2:0] {
    LID_SRC_LINK_10_1000,
    LID_SRC_LINK_100_1000,
    LID_SRC_LINK_ANY,
    LID_SRC_ACTIVITY,
    LID_SRC_LINK_IDLE,
    LID_SRC_LINK_10,
    LID_SRC_LINK_100,
    LID_SRC_LINK_1000
  } lid_src_t;

  typedef enum logic [1:0] {
    LID_SPD_10,
    LID_SPD_100,
    LID_SPD_1000,
    LID_SPD_NONE
  } lid_speed_t;

endpackage : lid_pkg

// [logic/lid_blink_gen.sv]
// Purpose: Free-running blink phase for all indicators.
// Assumes: Half periods are given in clock cycles.
// Notes:   A rate change restarts the half period so the new rate applies at once.
`timescale 1ns/10ps
`include "lid_regs.svh"
module lid_blink_gen
  import lid_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = 40000000,
  parameter int unsigned FAST_HALF_CYC = 16600000
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rate_fast,
  output logic phase_on
);

  logic [`LID_CNT_W-1:0] cnt_q;
  logic [`LID_CNT_W-1:0] cnt_d;
  logic [`LID_CNT_W-1:0] last_cnt;
  logic phase_q;
  logic phase_d;
  logic rate_q;
  logic rate_d;

  always_comb
  begin
    last_cnt = rate_fast ? `LID_CNT_W'(FAST_HALF_CYC - 1) : `LID_CNT_W'(SLOW_HALF_CYC - 1);
    rate_d = rate_fast;
    phase_d = phase_q;
    cnt_d = cnt_q + `LID_CNT_W'(1);
    if (rate_fast != rate_q)
    begin
      cnt_d = '0;
      phase_d = 1'b1;
    end
    else if (cnt_q >= last_cnt)
    begin
      // Each half period inverts the phase: equal on and off times.
      cnt_d = '0;
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      phase_q <= 1'b1;
      rate_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      rate_q <= rate_d;
    end
  end

  assign phase_on = phase_q;

endmodule : lid_blink_gen

// [logic/lid_ind_lane.sv]
// Purpose: One indicator: source decode, blink gating, polarity and pin flop.
// Assumes: Link state inputs are on the core clock.
// Notes:   The pin rests at its inactive level whenever the indication is off.
`timescale 1ns/10ps
module lid_ind_lane
  import lid_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] source_sel,
  input wire logic flash_en,
  input wire logic polarity,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic traffic_active,
  input wire logic phase_on,
  output logic pin_q,
  output logic ind_q
);

  logic ind_d;
  logic lit;
  logic pin_d;
  logic spd10;
  logic spd100;
  logic spd1000;

  always_comb
  begin
    spd10 = link_up && (lid_speed_t'(link_speed) == LID_SPD_10);
    spd100 = link_up && (lid_speed_t'(link_speed) == LID_SPD_100);
    spd1000 = link_up && (lid_speed_t'(link_speed) == LID_SPD_1000);
    unique case (lid_src_t'(source_sel))
      LID_SRC_LINK_10_1000: ind_d = spd10 || spd1000;
      LID_SRC_LINK_100_1000: ind_d = spd100 || spd1000;
      LID_SRC_LINK_ANY: ind_d = link_up;
      LID_SRC_ACTIVITY: ind_d = link_up && traffic_active;
      LID_SRC_LINK_IDLE: ind_d = link_up && !traffic_active;
      LID_SRC_LINK_10: ind_d = spd10;
      LID_SRC_LINK_100: ind_d = spd100;
      LID_SRC_LINK_1000: ind_d = spd1000;
    endcase
    // Blinking only gates an asserted indication.
    lit = ind_d && (!flash_en || phase_on);
    // Clear polarity drives low when lit, set polarity drives high.
    pin_d = polarity ? lit : !lit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pin_q <= 1'b1;
      ind_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_d;
      ind_q <= ind_d;
    end
  end

endmodule : lid_ind_lane

// [logic/lid_indicator.sv]
// Purpose: Link indicator driver: configuration register and three indicator pins.
// Assumes: Register port and link state inputs are on sys_clk.
// Notes:   Blink half periods are parameters so a simulation can shorten them.
`timescale 1ns/10ps
`include "lid_regs.svh"

// Overview of operation
// - Slow rate blinks 200 ms on/off.
// - Fast rate blinks 83 ms on/off.
// - Per-indicator blink enable at bits 14,9,4.
// - Polarity clear drives pin low when active.
// - Polarity set drives pin high when active.
// - Indicator two source bits 12:10, reset 110.
// - Indicator one source bits 7:5, reset 111.
// - Indicator zero source 2:0 reset 100, blink set.
// - Code 000: link at 10 or 1000.
// - Code 001: link at 100 or 1000.
// - Code 010: link at any speed.
// - Code 011: link up with traffic.
// - Code 100: link up without traffic.
// - Code 101: link at 10 only.
// - Code 110: link at 100 only.
// - Code 111: link at 1000 only.
module lid_indicator
  import lid_pkg::*;
#(
  parameter int unsigned SLOW_HALF_CYC = `LID_SLOW_HALF_MS * `LID_CLK_KHZ,
  parameter int unsigned FAST_HALF_CYC = `LID_FAST_HALF_MS * `LID_CLK_KHZ
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [`LID_ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr_en,
  input wire logic [`LID_DATA_W-1:0] cfg_wr_data,
  input wire logic cfg_rd_en,
  output logic [`LID_DATA_W-1:0] cfg_rd_data,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic traffic_active,
  output logic indicator_out_zero,
  output logic indicator_out_one,
  output logic indicator_out_two
);

  logic [`LID_DATA_W-1:0] cfg_q;
  logic [`LID_DATA_W-1:0] cfg_d;
  logic [`LID_DATA_W-1:0] rd_q;
  logic [`LID_DATA_W-1:0] rd_d;
  logic hit;
  logic phase_on;
  logic [2:0] sel [3];
  logic [2:0] flash;
  logic [2:0] pol;
  logic [2:0] pins;

  // Register write and registered read-back; other addresses read zero.
  always_comb
  begin
    hit = (cfg_addr == `LID_CFG_ADDR);
    cfg_d = cfg_q;
    if (cfg_wr_en && hit)
    begin
      cfg_d = cfg_wr_data;
    end
    rd_d = rd_q;
    if (cfg_rd_en)
    begin
      rd_d = hit ? cfg_q : '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cfg_q <= `LID_CFG_RESET;
      rd_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      rd_q <= rd_d;
    end
  end

  assign cfg_rd_data = rd_q;

  // Field extraction per indicator.
  assign sel[0] = cfg_q[`LID_SEL0_HI:`LID_SEL0_LO];
  assign sel[1] = cfg_q[`LID_SEL1_HI:`LID_SEL1_LO];
  assign sel[2] = cfg_q[`LID_SEL2_HI:`LID_SEL2_LO];
  assign flash = {cfg_q[`LID_FLASH2_BIT], cfg_q[`LID_FLASH1_BIT], cfg_q[`LID_FLASH0_BIT]};
  assign pol = {cfg_q[`LID_POL2_BIT], cfg_q[`LID_POL1_BIT], cfg_q[`LID_POL0_BIT]};

  // One shared blink phase keeps all blinking indicators in step.
  lid_blink_gen #(
    .SLOW_HALF_CYC(SLOW_HALF_CYC),
    .FAST_HALF_CYC(FAST_HALF_CYC)
  ) u_blink (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .rate_fast(cfg_q[`LID_RATE_BIT]),
    .phase_on(phase_on)
  );

  // Polarity and blink are applied as written, even against the
  // recommended combinations; software owns those choices.
  for (genvar i = 0; i < 3; i++)
  begin : g_lane
    lid_ind_lane u_lane (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .source_sel(sel[i]),
      .flash_en(flash[i]),
      .polarity(pol[i]),
      .link_up(link_up),
      .link_speed(link_speed),
      .traffic_active(traffic_active),
      .phase_on(phase_on),
      .pin_q(pins[i]),
      .ind_q()
    );
  end

  assign indicator_out_zero = pins[0];
  assign indicator_out_one = pins[1];
  assign indicator_out_two = pins[2];

endmodule : lid_indicator

// [tb/lid_indicator_chk.sv]
// Purpose: Port checker for lid_indicator.
// Assumes: cfg_q mirrors the configuration register.
// Notes: Bound after the module.
`timescale 1ns/10ps
`include "lid_regs.svh"
module lid_indicator_chk
  import lid_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [`LID_ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr_en,
  input wire logic [`LID_DATA_W-1:0] cfg_wr_data,
  input wire logic cfg_rd_en,
  input wire logic [`LID_DATA_W-1:0] cfg_rd_data,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic traffic_active,
  input wire logic indicator_out_zero,
  input wire logic indicator_out_one,
  input wire logic indicator_out_two
);
  logic [15:0] cfg_d, cfg_q;
  logic [7:0] tab;
  logic [2:0] ind;
  always_comb
  begin
    tab = {link_speed == 2'h2, link_speed == 2'h1, link_speed == 2'h0, !traffic_active,
      traffic_active, 1'b1, link_speed == 2'h1 || link_speed == 2'h2,
      link_speed == 2'h0 || link_speed == 2'h2};
    ind = {3{link_up}} & {tab[cfg_q[12:10]], tab[cfg_q[7:5]], tab[cfg_q[2:0]]};
    cfg_d = (cfg_wr_en && cfg_addr == `LID_CFG_ADDR) ? cfg_wr_data : cfg_q;
    if (!rst_b)
      cfg_d = 16'h18F4;
  end
  always_ff @(posedge sys_clk)
    cfg_q <= cfg_d;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_read_map: assert property (cfg_rd_en && cfg_addr == `LID_CFG_ADDR |=>
    cfg_rd_data == $past(cfg_q)) else $error("read map");
  a_read_other: assert property (cfg_rd_en && cfg_addr != `LID_CFG_ADDR |=>
    cfg_rd_data == 16'h0) else $error("read other");
  a_read_hold: assert property (!cfg_rd_en |=> $stable(cfg_rd_data))
    else $error("read hold");
  a_rst_read: assert property (disable iff (1'b0) !rst_b |=> cfg_rd_data == 16'h0)
    else $error("reset read");
  a_rst_pins: assert property (disable iff (1'b0) !rst_b |=>
    {indicator_out_two, indicator_out_one, indicator_out_zero} == 3'h7) else $error("reset pin");
  a_lane_zero: assert property (!(cfg_q[4] && ind[0]) |=>
    indicator_out_zero == $past(cfg_q[3] ~^ ind[0])) else $error("lane zero");
  a_lane_one: assert property (!(cfg_q[9] && ind[1]) |=>
    indicator_out_one == $past(cfg_q[8] ~^ ind[1])) else $error("lane one");
  a_lane_two: assert property (!(cfg_q[14] && ind[2]) |=>
    indicator_out_two == $past(cfg_q[13] ~^ ind[2])) else $error("lane two");
endmodule : lid_indicator_chk
bind lid_indicator lid_indicator_chk chk_u (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .cfg_addr(cfg_addr),
  .cfg_wr_en(cfg_wr_en),
  .cfg_wr_data(cfg_wr_data),
  .cfg_rd_en(cfg_rd_en),
  .cfg_rd_data(cfg_rd_data),
  .link_up(link_up),
  .link_speed(link_speed),
  .traffic_active(traffic_active),
  .indicator_out_zero(indicator_out_zero),
  .indicator_out_one(indicator_out_one),
  .indicator_out_two(indicator_out_two)
);

// [tb/lid_led_bank.sv]
// Purpose: Board lamp model; times each run of lamp zero.
// Assumes: Lamp pin sampled on sys_clk.
// Notes: run_len holds the last finished run.
`timescale 1ns/10ps
module lid_led_bank
  import lid_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pin,
  output logic [31:0] run_len
);
  logic [31:0] cnt_q = 32'h0;
  logic prev_q = 1'b0;
  always @(posedge sys_clk)
  begin
    prev_q <= pin;
    cnt_q <= (pin == prev_q) ? cnt_q + 32'h1 : 32'h1;
    if (pin != prev_q)
      run_len <= cnt_q;
  end
endmodule : lid_led_bank

// [tb/tb_top.sv]
// Purpose: Self-checking bench for lid_indicator.
// Assumes: Blink half periods shortened to 8 and 4 cycles.
// Notes: A monitor checks each read against the oldest queued word.
`timescale 1ns/10ps
`include "lid_regs.svh"
module tb_top
  import lid_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, rd_seen = 1'b0;
  logic [4:0] cfg_addr = 5'h0;
  logic [15:0] cfg_wr_data = 16'h0, cfg_rd_data, d;
  logic link_up = 1'b0, traffic_active = 1'b0, f, e;
  logic [1:0] link_speed = 2'h3;
  logic [2:0] pin, p;
  logic [31:0] run_len, seed = 32'h9BCD;
  logic [15:0] exp_q[$];
  int err_total = 0, checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  lid_indicator #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(4)) dut_u (.sys_clk(sys_clk),
    .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_en(cfg_rd_en), .cfg_rd_data(cfg_rd_data), .link_up(link_up),
    .link_speed(link_speed), .traffic_active(traffic_active), .indicator_out_zero(pin[0]),
    .indicator_out_one(pin[1]), .indicator_out_two(pin[2]));
  lid_led_bank led_u (.sys_clk(sys_clk), .pin(pin[0]), .run_len(run_len));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Expected indication per source code, bit n of the table is code n.
  function automatic logic src_ind(input logic [2:0] sel, input logic up,
    input logic [1:0] spd, input logic act);
    logic [7:0] t;
    t = {spd == 2'h2, spd == 2'h1, spd == 2'h0, !act, act, 1'b1, spd == 2'h1 || spd == 2'h2,
      spd == 2'h0 || spd == 2'h2};
    return up && t[sel];
  endfunction : src_ind
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    cfg_addr = a;
    cfg_wr_data = v;
    cfg_wr_en = 1'b1;
    @(posedge sys_clk);
    #1 cfg_wr_en = 1'b0;
    // One idle edge keeps a following call from rewriting a strobe in the same step.
    @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] v);
    cfg_addr = a;
    cfg_rd_en = 1'b1;
    exp_q.push_back(v);
    @(posedge sys_clk);
    #1 cfg_rd_en = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : rd
  always @(posedge sys_clk)
  begin
    rd_seen <= cfg_rd_en;
    if (rd_seen)
      chk("cfg_rd_data", cfg_rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rd(`LID_CFG_ADDR, 16'h18F4);
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      d = seed[15:0];
      d = d & ~{2'h0, d[14], 4'h0, d[9], 4'h0, d[4], 3'h0};
      link_speed = seed[17:16];
      link_up = seed[17:16] != 2'h3;
      traffic_active = seed[18];
      wr(`LID_CFG_ADDR, d);
      rd(`LID_CFG_ADDR, d);
    end
    wr(5'h1D, 16'hFFFF);
    rd(5'h1D, 16'h0);
    rd(`LID_CFG_ADDR, d);
    for (int s = 0; s < 8; s++)
    begin
      seed = xs(seed);
      f = s == 3 || s == 4;
      p = seed[2:0] & {3{!f}};
      wr(`LID_CFG_ADDR, {1'b0, f, p[2], s[2:0], f, p[1], s[2:0], f, p[0], s[2:0]});
      for (int k = 0; k < 8; k++)
      begin
        link_speed = k[1:0];
        link_up = k[1:0] != 2'h3;
        traffic_active = k[2];
        repeat (2) @(posedge sys_clk);
        #1;
        for (int i = 0; i < 3; i++)
        begin
          e = src_ind(s[2:0], link_up, link_speed, traffic_active);
          if (!f || !e)
            chk("indicator pin", pin[i], 1'(p[i] ~^ e));
        end
      end
    end
    link_speed = 2'h2;
    link_up = 1'b1;
    wr(`LID_CFG_ADDR, 16'h0012);
    repeat (40) @(posedge sys_clk);
    #1 chk("run_len", run_len, 32'h8);
    wr(`LID_CFG_ADDR, 16'h8012);
    repeat (40) @(posedge sys_clk);
    #1 chk("run_len", run_len, 32'h4);
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rd(`LID_CFG_ADDR, `LID_CFG_RESET);
    chk("pins after reset", pin, 32'h5);
    chk("pending", exp_q.size(), 32'h0);
    close_out();
  end
endmodule : tb_top
